//--- arsi_pkg.sv
package arsi_pkg;

  // register word addresses on the plain port
  localparam logic [5:0] ARSI_A_RESULT0  = 6'h00;  // 0x00..0x0F result slots
  localparam logic [5:0] ARSI_A_CTRL0    = 6'h10;  // 0x10..0x1F slot control
  localparam logic [5:0] ARSI_A_IRQ_EN   = 6'h20;
  localparam logic [5:0] ARSI_A_FLAGS    = 6'h21;
  localparam logic [5:0] ARSI_A_VECTOR   = 6'h22;
  localparam logic [5:0] ARSI_A_CONFIG   = 6'h23;
  localparam logic [5:0] ARSI_A_EVT_STAT = 6'h24;
  localparam logic [5:0] ARSI_A_EVT_CLR  = 6'h25;
  localparam logic [5:0] ARSI_A_EVT_EN   = 6'h26;

  // config register fields
  localparam int ARSI_CF_FORMAT = 0;   // result_format_select
  localparam int ARSI_CF_RES_LO = 1;   // resolution_select, 2 bits
  localparam int ARSI_CF_ENC    = 3;   // conversion_enable_bit
  localparam int ARSI_CF_OVIE   = 4;   // overflow_irq_enable
  localparam int ARSI_CF_TOVIE  = 5;   // conv_time_overflow_irq_enable
  localparam int ARSI_CF_GIE    = 6;   // global_irq_enable
  localparam int ARSI_CF_W      = 7;

  // resolution_select codes
  localparam logic [1:0] ARSI_RES_8  = 2'h0;
  localparam logic [1:0] ARSI_RES_10 = 2'h1;
  localparam logic [1:0] ARSI_RES_12 = 2'h2;

  // vector codes
  localparam logic [4:0] ARSI_VEC_NONE = 5'h00;
  localparam logic [4:0] ARSI_VEC_OVF  = 5'h01;  // reads 002h
  localparam logic [4:0] ARSI_VEC_TOV  = 5'h02;  // reads 004h
  localparam logic [4:0] ARSI_VEC_SLOT = 5'h03;  // slot 0 reads 006h

  // event status bits
  localparam int ARSI_EV_DONE = 0;
  localparam int ARSI_EV_OVF  = 1;
  localparam int ARSI_EV_TOV  = 2;
  localparam int ARSI_EV_W    = 3;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } arsi_bus_t;

  typedef struct packed {
    logic        valid;   // one-cycle pulse
    logic [3:0]  slot;
    logic [11:0] data;    // right-justified raw result
  } arsi_conv_t;

endpackage

//--- arsi_top.sv
// Notes on behaviour
// R1 - format 0 reads right-justified unsigned, unused upper bits zero.
// R2 - a software write to a result slot replaces the stored result.
// R3 - format 1 reads left-justified two's complement, low bits zero.
// R4 - slots store unsigned right-justified data; reads convert.
// R5 - a 16-bit enable register gates each slot done flag onto the request; here it gates only the vector, irq_o follows the done event of every load.
// R6 - loading a conversion result into slot n sets done flag n.
// R7 - accessing slot n clears flag n; software may also write the flags.
// R8 - vector reads 000h idle, 002h, 004h, then 006h+2n for slot n last.
// R9 - both overflow sources need their own enable and the global enable; here only for the vector, irq_o needs just the event enable.
// R10 - slot control (marker, reference, channel) is writable only when off.
// R11 - the vector is read-only, bits 15..6 and 0 zero, reset to zero.
//
// Decided for this implementation: the address map and the address-and-strobe port.
module arsi_top
  import arsi_pkg::*;
#(
  parameter int N_SLOTS = 16
) (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [5:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o,
  input  wire logic        conv_valid_i,
  input  wire logic [3:0]  conv_slot_i,
  input  wire logic [11:0] conv_data_i,
  input  wire logic        overflow_i,
  input  wire logic        time_overflow_i,
  output logic             conv_enable_o,
  output logic             irq_o
);

  if (N_SLOTS != 16) begin : g_bad_slots
    $error("arsi_top serves exactly 16 slots");
  end

  typedef struct packed {
    logic [15:0][11:0]     result;
    logic [15:0][7:0]      ctrl;
    logic [15:0]           irq_en;
    logic [15:0]           flags;
    logic [ARSI_CF_W-1:0]  cfg;
    logic                  ovf_pend;
    logic                  tov_pend;
    logic [ARSI_EV_W-1:0]  ev_stat;
    logic [ARSI_EV_W-1:0]  ev_en;
    logic [4:0]            vec;
    logic [15:0]           rdata;
    logic                  irq;
  } arsi_state_t;

  arsi_state_t s_q, s_d;
  arsi_bus_t   bus;
  arsi_conv_t  cv;
  logic        rst_meta_q, rst_sync_q;
  logic        ov_m_q, ov_s_q, tv_m_q, tv_s_q;

  assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
  assign cv  = '{valid: conv_valid_i, slot: conv_slot_i, data: conv_data_i};

  // reset release through two flops
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // overflow strobes come from the analog clock side, so synchronise
  always_ff @(posedge clock_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ov_m_q <= 1'b0;
      ov_s_q <= 1'b0;
      tv_m_q <= 1'b0;
      tv_s_q <= 1'b0;
    end else begin
      ov_m_q <= overflow_i;
      ov_s_q <= ov_m_q;
      tv_m_q <= time_overflow_i;
      tv_s_q <= tv_m_q;
    end
  end

  // read path formatting of one raw result
  function automatic logic [15:0] fmt(input logic [11:0] raw,
                                      input logic        signed_fmt,
                                      input logic [1:0]  res);
    logic [15:0] v;
    v = 16'h0000;
    if (!signed_fmt) begin
      unique case (res)                                   // R1
        ARSI_RES_8:  v = {8'h00, raw[7:0]};
        ARSI_RES_10: v = {6'h00, raw[9:0]};
        default:     v = {4'h0, raw};
      endcase
    end else begin
      // offset binary to two's complement: flip the top bit  R3
      unique case (res)
        ARSI_RES_8:  v = {~raw[7], raw[6:0], 8'h00};
        ARSI_RES_10: v = {~raw[9], raw[8:0], 6'h00};
        default:     v = {~raw[11], raw[10:0], 4'h0};
      endcase
    end
    return v;
  endfunction

  // next-state logic for the whole block
  always_comb begin
    logic [3:0]  sl;
    logic        slot_hit;
    logic [15:0] pend;
    logic        ev_done;
    s_d      = s_q;
    sl       = bus.addr[3:0];
    slot_hit = (bus.addr[5:4] == ARSI_A_RESULT0[5:4]);
    ev_done  = 1'b0;
    pend     = 16'h0000;

    // software clears first, hardware sets afterwards so sets win
    if (bus.wr) begin
      if (slot_hit) s_d.result[sl] = bus.wdata[11:0];      // R2 R4
      if (bus.addr[5:4] == ARSI_A_CTRL0[5:4] && !s_q.cfg[ARSI_CF_ENC])
        s_d.ctrl[sl] = bus.wdata[7:0];                    // R10
      if (bus.addr == ARSI_A_IRQ_EN) s_d.irq_en = bus.wdata; // R5
      if (bus.addr == ARSI_A_FLAGS)  s_d.flags  = bus.wdata; // R7
      if (bus.addr == ARSI_A_CONFIG) s_d.cfg = bus.wdata[ARSI_CF_W-1:0];
      if (bus.addr == ARSI_A_EVT_CLR)
        s_d.ev_stat = s_q.ev_stat & ~bus.wdata[ARSI_EV_W-1:0];
      if (bus.addr == ARSI_A_EVT_STAT) begin
        s_d.ovf_pend = 1'b0;  // status write also acks overflows
        s_d.tov_pend = 1'b0;
      end
    end
    if ((bus.wr || bus.rd) && slot_hit) s_d.flags[sl] = 1'b0; // R7

    // conversion load: after software so the flag set wins
    if (cv.valid) begin
      if (s_q.flags[cv.slot]) s_d.ovf_pend = 1'b1;  // unread slot overwritten
      s_d.result[cv.slot] = cv.data;                // R4
      s_d.flags[cv.slot]  = 1'b1;                   // R6
      ev_done             = 1'b1;
    end
    if (ov_s_q) s_d.ovf_pend = 1'b1;
    if (tv_s_q) s_d.tov_pend = 1'b1;

    s_d.ev_stat = s_d.ev_stat
                | {tv_s_q, (ov_s_q | (cv.valid & s_q.flags[cv.slot])), ev_done};
    if (bus.wr && bus.addr == ARSI_A_EVT_EN)
      s_d.ev_en = bus.wdata[ARSI_EV_W-1:0];

    // priority encoder, from the registered state
    pend = s_q.flags & s_q.irq_en;                                 // R5
    s_d.vec = ARSI_VEC_NONE;
    for (int i = 15; i >= 0; i--) begin
      if (pend[i]) s_d.vec = ARSI_VEC_SLOT + 5'(i);                // R8
    end
    if (s_q.cfg[ARSI_CF_GIE]) begin                                // R9
      if (s_q.tov_pend && s_q.cfg[ARSI_CF_TOVIE]) s_d.vec = ARSI_VEC_TOV;
      if (s_q.ovf_pend && s_q.cfg[ARSI_CF_OVIE])  s_d.vec = ARSI_VEC_OVF;
    end else if (!(|pend)) begin
      s_d.vec = ARSI_VEC_NONE;
    end

    // read data appears the cycle after the strobe only
    s_d.rdata = 16'h0000;
    if (bus.rd) begin
      if (slot_hit)
        s_d.rdata = fmt(s_q.result[sl], s_q.cfg[ARSI_CF_FORMAT],
                        s_q.cfg[ARSI_CF_RES_LO +: 2]);             // R1 R3
      else if (bus.addr[5:4] == ARSI_A_CTRL0[5:4])
        s_d.rdata = {8'h00, s_q.ctrl[sl]};
      else if (bus.addr == ARSI_A_IRQ_EN)  s_d.rdata = s_q.irq_en;
      else if (bus.addr == ARSI_A_FLAGS)   s_d.rdata = s_q.flags;
      else if (bus.addr == ARSI_A_VECTOR)
        s_d.rdata = {10'h000, s_q.vec, 1'b0};                      // R11
      else if (bus.addr == ARSI_A_CONFIG)
        s_d.rdata = {9'h000, s_q.cfg};
      else if (bus.addr == ARSI_A_EVT_STAT)
        s_d.rdata = {13'h0000, s_q.ev_stat};
      else if (bus.addr == ARSI_A_EVT_EN)
        s_d.rdata = {13'h0000, s_q.ev_en};
    end

    s_d.irq = |(s_d.ev_stat & s_d.ev_en);
  end

  // single state register
  always_ff @(posedge clock_i or negedge rst_sync_q) begin
    if (!rst_sync_q) s_q <= '0;
    else             s_q <= s_d;
  end

  assign rdata_o       = s_q.rdata;
  assign conv_enable_o = s_q.cfg[ARSI_CF_ENC];
  assign irq_o         = s_q.irq;

  // checks: one clock domain, so clock and disable are stated once
  default clocking chk_cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_sync_q);

  // decodes shared by the checks, taken from the bus as it stands
  logic        slot_rd;
  logic        slot_wr;
  logic        ctrl_wr;
  logic        fmt_sel;
  logic [1:0]  res_sel;
  logic [11:0] slot_raw;
  logic [15:0] slot_pend;

  assign slot_rd   = rd_i && addr_i[5:4] == ARSI_A_RESULT0[5:4];
  assign slot_wr   = wr_i && addr_i[5:4] == ARSI_A_RESULT0[5:4];
  assign ctrl_wr   = wr_i && addr_i[5:4] == ARSI_A_CTRL0[5:4];
  assign fmt_sel   = s_q.cfg[ARSI_CF_FORMAT];
  assign res_sel   = s_q.cfg[ARSI_CF_RES_LO +: 2];
  assign slot_raw  = s_q.result[addr_i[3:0]];
  assign slot_pend = s_q.flags & s_q.irq_en;

  // a load lands in its slot and raises that slot's flag
  a_load_sets_flag: assert property (                             // R6
    conv_valid_i |=> s_q.flags[$past(conv_slot_i)])
    else $error("slot flag not set after load");

  a_load_stores: assert property (                                // R4
    conv_valid_i
      |=> s_q.result[$past(conv_slot_i)] == $past(conv_data_i))
    else $error("result not stored");

  // software write replaces the stored result unless a load collides
  a_sw_write_slot: assert property (                              // R2
    slot_wr && !conv_valid_i
      |=> s_q.result[$past(addr_i[3:0])] == $past(wdata_i[11:0]))
    else $error("software slot write lost");

  // any slot access clears the flag when no load races it
  a_access_clears: assert property (                              // R7
    (slot_rd || slot_wr) && !conv_valid_i
      |=> !s_q.flags[$past(addr_i[3:0])])
    else $error("slot access did not clear flag");

  // a flag register write replaces every flag
  a_flag_write: assert property (                                 // R7
    wr_i && addr_i == ARSI_A_FLAGS && !conv_valid_i
      |=> s_q.flags == $past(wdata_i))
    else $error("flag register write lost");

  // unsigned reads keep the unused upper bits at zero
  a_unsigned_read: assert property (                              // R1
    slot_rd && !fmt_sel && res_sel == ARSI_RES_10
      |=> rdata_o[15:10] == 6'h00)
    else $error("unsigned read upper bits not zero");

  a_unsigned_8: assert property (                                 // R1
    slot_rd && !fmt_sel && res_sel == ARSI_RES_8
      |=> rdata_o[15:8] == 8'h00)
    else $error("unsigned 8-bit read upper bits not zero");

  a_unsigned_12: assert property (                                // R1
    slot_rd && !fmt_sel && res_sel == ARSI_RES_12
      |=> rdata_o == {4'h0, $past(slot_raw)})
    else $error("unsigned 12-bit read wrong");

  // signed reads flip the top bit and left-align
  a_signed_read: assert property (                                // R3
    slot_rd && fmt_sel && res_sel == ARSI_RES_12
      |=> rdata_o == {~$past(slot_raw[11]),
                      $past(slot_raw[10:0]), 4'h0})
    else $error("signed read wrong");

  a_signed_low_10: assert property (                              // R3
    slot_rd && fmt_sel && res_sel == ARSI_RES_10
      |=> rdata_o[5:0] == 6'h00)
    else $error("signed 10-bit read low bits not zero");

  a_signed_low_8: assert property (                               // R3
    slot_rd && fmt_sel && res_sel == ARSI_RES_8
      |=> rdata_o[7:0] == 8'h00)
    else $error("signed 8-bit read low bits not zero");

  // the vector is built from last cycle's state, so look one back
  a_enable_gates: assert property (                               // R5
    s_q.vec >= ARSI_VEC_SLOT
      |-> |($past(slot_pend)
            & (16'h0001 << (s_q.vec - ARSI_VEC_SLOT))))
    else $error("vector names a disabled slot");

  // overflow outranks everything once enabled
  a_vec_prio: assert property (                                   // R8
    s_q.cfg[ARSI_CF_GIE] && s_q.cfg[ARSI_CF_OVIE] && s_q.ovf_pend
      |=> s_q.vec == ARSI_VEC_OVF)
    else $error("overflow not top priority");

  a_tov_prio: assert property (                                   // R8
    s_q.cfg[ARSI_CF_GIE] && s_q.cfg[ARSI_CF_TOVIE] && s_q.tov_pend
      && !(s_q.cfg[ARSI_CF_OVIE] && s_q.ovf_pend)
      |=> s_q.vec == ARSI_VEC_TOV)
    else $error("time overflow not second priority");

  // nothing enabled and pending means the idle code
  a_vec_idle: assert property (                                   // R8
    slot_pend == 16'h0000
      && !(s_q.cfg[ARSI_CF_GIE]
           && ((s_q.ovf_pend && s_q.cfg[ARSI_CF_OVIE])
               || (s_q.tov_pend && s_q.cfg[ARSI_CF_TOVIE])))
      |=> s_q.vec == ARSI_VEC_NONE)
    else $error("vector not idle");

  // slot codes still show without the global enable
  a_vec_slot: assert property (                                   // R9
    !s_q.cfg[ARSI_CF_GIE] && slot_pend != 16'h0000
      |=> s_q.vec >= ARSI_VEC_SLOT)
    else $error("slot vector missing");

  a_gie_gates: assert property (                                  // R9
    !s_q.cfg[ARSI_CF_GIE]
      |=> s_q.vec != ARSI_VEC_OVF && s_q.vec != ARSI_VEC_TOV)
    else $error("overflow vector without global enable");

  // slot control only moves while conversions are off
  a_ctrl_locked: assert property (                                // R10
    ctrl_wr && s_q.cfg[ARSI_CF_ENC]
      |=> $stable(s_q.ctrl))
    else $error("slot control changed while enabled");

  a_ctrl_write: assert property (                                 // R10
    ctrl_wr && !s_q.cfg[ARSI_CF_ENC]
      |=> s_q.ctrl[$past(addr_i[3:0])] == $past(wdata_i[7:0]))
    else $error("slot control write lost");

  // reserved vector bits always read zero
  a_vec_read: assert property (                                   // R11
    rd_i && addr_i == ARSI_A_VECTOR
      |=> rdata_o[15:6] == 10'h000 && !rdata_o[0])
    else $error("vector reserved bits set");

  // main scenarios worth seeing at least once
  c_load: cover property (conv_valid_i ##1 irq_o);
  c_signed: cover property (slot_rd && fmt_sel);
  c_overflow: cover property (s_q.vec == ARSI_VEC_OVF);
  c_time_ovf: cover property (s_q.vec == ARSI_VEC_TOV);
  c_last_slot: cover property (s_q.vec == ARSI_VEC_SLOT + 5'h0F);

endmodule // arsi_top

//--- testbench.sv
module testbench
  import arsi_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [5:0]  addr_i = 6'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] rdata_o;
  logic        conv_valid_i = 1'b0;
  logic [3:0]  conv_slot_i = 4'h0;
  logic [11:0] conv_data_i = 12'h000;
  logic        overflow_i = 1'b0;
  logic        time_overflow_i = 1'b0;
  logic        conv_enable_o;
  logic        irq_o;
  int          n_errors = 0;
  int          comparisons = 0;

  arsi_top dut_u (.clock_i(clock_i), .arst_n_i(arst_n_i), .wr_i(wr_i),
    .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .conv_valid_i(conv_valid_i), .conv_slot_i(conv_slot_i),
    .conv_data_i(conv_data_i), .overflow_i(overflow_i),
    .time_overflow_i(time_overflow_i), .conv_enable_o(conv_enable_o),
    .irq_o(irq_o));

  // 250 MHz system clock
  always #2 clock_i = ~clock_i;

  task automatic close_out();
    $display("counts: %0d compared, %0d mismatched", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one-cycle strobes, changed only right after a rising edge
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [5:0] a, logic [15:0] e);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(nm, rdata_o, e);
  endtask

  task automatic conv(input logic [3:0] s, input logic [11:0] d);
    @(posedge clock_i);
    conv_valid_i <= 1'b1;
    conv_slot_i <= s;
    conv_data_i <= d;
    @(posedge clock_i);
    conv_valid_i <= 1'b0;
  endtask

  // event inputs pass a two-flop synchroniser, so hold and then settle
  task automatic pulse(input bit tov);
    @(posedge clock_i);
    if (tov) time_overflow_i <= 1'b1;
    else overflow_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    time_overflow_i <= 1'b0;
    overflow_i <= 1'b0;
    repeat (6) @(posedge clock_i);
  endtask

  task automatic wait_irq(input logic e);
    int i;
    #1;
    // sample off the edge that launches the output
    for (i = 0; i < 10 && irq_o !== e; i++) begin
      @(posedge clock_i);
      #1;
    end
    chk("irq_o", {15'h0, irq_o}, {15'h0, e});
    if (irq_o !== e) close_out();
  endtask

  task automatic t_reset();
    rchk("slot irq enable", ARSI_A_IRQ_EN, 16'h0000);
    rchk("done flags", ARSI_A_FLAGS, 16'h0000);
    rchk("vector", ARSI_A_VECTOR, 16'h0000);
    $display("test reset done");
  endtask

  // same stored raw value read in both formats at each resolution
  task automatic t_format();
    logic [11:0] raw;
    logic [15:0] e;
    int          w;
    for (int r = 0; r < 3; r++) begin
      w = 12 - 2 * r;
      raw = 12'hA5C >> (2 * r);
      wr(ARSI_A_CONFIG, 16'({2'(2 - r), 1'b0}));
      conv(4'(r), raw);
      rchk("done flags", ARSI_A_FLAGS, 16'h1 << r);
      rchk("unsigned", 6'(r), 16'(raw));
      wr(ARSI_A_CONFIG, 16'({2'(2 - r), 1'b1}));
      e = 16'(raw ^ (12'h1 << (w - 1))) << (16 - w);
      rchk("signed", 6'(r), e);
      rchk("flag cleared", ARSI_A_FLAGS, 16'h0000);
    end
    wr(ARSI_A_CONFIG, 16'h0004);
    $display("test format done");
  endtask

  task automatic t_slot_write();
    conv(4'h5, 12'h321);
    wr(ARSI_A_RESULT0 + 6'h05, 16'h0ABC);
    rchk("flag cleared", ARSI_A_FLAGS, 16'h0000);
    rchk("written slot", ARSI_A_RESULT0 + 6'h05, 16'h0ABC);
    $display("test slot write done");
  endtask

  task automatic t_vector();
    wr(ARSI_A_IRQ_EN, 16'hFFFF);
    conv(4'h7, 12'h111);
    conv(4'h2, 12'h222);
    rchk("vector", ARSI_A_VECTOR, 16'h000A);
    wr(ARSI_A_IRQ_EN, 16'hFFFB);
    rchk("vector masked", ARSI_A_VECTOR, 16'h0014);
    wr(ARSI_A_IRQ_EN, 16'hFFFF);
    wr(ARSI_A_FLAGS, 16'h8000);
    rchk("vector lowest", ARSI_A_VECTOR, 16'h0024);
    wr(ARSI_A_FLAGS, 16'h0001);
    wr(ARSI_A_CONFIG, 16'h0034);
    pulse(1'b0);
    rchk("vector no gie", ARSI_A_VECTOR, 16'h0006);
    wr(ARSI_A_CONFIG, 16'h0074);
    rchk("vector overflow", ARSI_A_VECTOR, 16'h0002);
    wr(ARSI_A_EVT_STAT, 16'h0000);
    pulse(1'b1);
    rchk("vector time ovf", ARSI_A_VECTOR, 16'h0004);
    wr(ARSI_A_EVT_STAT, 16'h0000);
    wr(ARSI_A_FLAGS, 16'h0000);
    wr(ARSI_A_CONFIG, 16'h0004);
    rchk("vector idle", ARSI_A_VECTOR, 16'h0000);
    $display("test vector done");
  endtask

  task automatic t_irq();
    wr(ARSI_A_EVT_CLR, 16'h0007);
    wr(ARSI_A_EVT_EN, 16'h0001);
    conv(4'h9, 12'h0F0);
    wait_irq(1'b1);
    rchk("event status", ARSI_A_EVT_STAT, 16'h0001);
    wr(ARSI_A_EVT_EN, 16'h0000);
    wait_irq(1'b0);
    wr(ARSI_A_EVT_EN, 16'h0001);
    wait_irq(1'b1);
    wr(ARSI_A_EVT_CLR, 16'h0001);
    wait_irq(1'b0);
    rchk("clear reads zero", ARSI_A_EVT_CLR, 16'h0000);
    rchk("unmapped", 6'h3F, 16'h0000);
    rchk("slot 9", ARSI_A_RESULT0 + 6'h09, 16'h00F0);
    // a second load into an unread slot counts as an overflow
    wr(ARSI_A_EVT_CLR, 16'h0007);
    conv(4'h3, 12'h333);
    conv(4'h3, 12'h334);
    rchk("overflow event", ARSI_A_EVT_STAT, 16'h0003);
    rchk("slot 3 newest", ARSI_A_RESULT0 + 6'h03, 16'h0334);
    wr(ARSI_A_EVT_STAT, 16'h0000);
    $display("test irq done");
  endtask

  // slot control is frozen while conversions are enabled
  task automatic t_ctrl();
    wr(ARSI_A_CTRL0 + 6'h04, 16'h00B7);
    rchk("slot control", ARSI_A_CTRL0 + 6'h04, 16'h00B7);
    wr(ARSI_A_CONFIG, 16'h000C);
    #1 chk("conv enable", {15'h0, conv_enable_o}, 16'h0001);
    wr(ARSI_A_CTRL0 + 6'h04, 16'h0042);
    rchk("control locked", ARSI_A_CTRL0 + 6'h04, 16'h00B7);
    wr(ARSI_A_CONFIG, 16'h0004);
    $display("test control done");
  endtask

  initial begin
    #100us;
    n_errors++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_reset();
    t_format();
    t_slot_write();
    t_vector();
    t_irq();
    t_ctrl();
    close_out();
  end

endmodule // testbench
